// ### verif/testbench.sv
// Self-checking bench for the gesture and offset configuration registers.
// Assumes the bench acts as the only AHB-Lite master and drives every sensor-side input.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam int MSC = 4;
    localparam int DTAP [8] = '{50, 100, 150, 200, 250, 375, 500, 700};
    localparam int HOLD [4] = '{0, 640, 1280, 2560};
    localparam logic [7:0] RSTV [7] = '{8'h04, 8'h0a, 8'h18, 8'h48, 8'h08, 8'h11, 8'h00};
    localparam logic [7:0] MSKV [7] = '{8'hc7, 8'h1f, 8'hff, 8'hff, 8'h3f, 8'h37, 8'h7f};
    // Bus side.
    logic                      hclk = 1'b0;
    logic                      hresetn = 1'b0;
    logic                      ce = 1'b1;
    logic                      hsel = 1'b0;
    logic [11:0]               haddr = 12'h000;
    logic [1:0]                htrans = 2'h0;
    logic                      hwrite = 1'b0;
    logic [31:0]               hwdata = 32'h0;
    logic                      hreadyout, hresp;
    logic [31:0]               hrdata;
    // Sensor side.
    logic [1:0]                acc_range = 2'h0;
    logic [15:0]               acc_x = 16'h0, acc_y = 16'h0, acc_z = 16'h0;
    logic                      tap_prefilt = 1'b0, ud_change = 1'b0, flat_now = 1'b0;
    logic [2:0]                orient_value = 3'h0;
    mgc_pkg::mgc_ms_t          tap_quiet_ms, tap_shock_ms, tap_window_ms, flat_hold_ms;
    logic [8:0]                tap_threshold_half;
    logic [3:0]                orient_hyst;
    mgc_pkg::mgc_orient_mode_t orient_mode;
    logic [2:0]                orient_slope_dg, flat_hysteresis;
    logic [5:0]                orient_theta, flat_theta;
    logic [15:0]               orient_x, orient_y, orient_z;
    logic                      lowpower_allow, orient_block_theta, orient_block_big;
    logic                      orient_block_unstable, orient_ud_irq, flat_settled, foc_gyr_en;
    mgc_pkg::mgc_foc_target_t  foc_x, foc_y, foc_z;
    // Model and bookkeeping.
    logic [7:0]                mr [7];
    logic [31:0]               q, d;
    int                        err_count = 0;
    int                        checks = 0;
    int                        seed = 32'ha7e2;

    mgc_config_regs #(.ADDR_W(12), .MS_CYCLES(MSC)) mgc_config_regs_inst (
        .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .acc_range(acc_range),
        .acc_x(acc_x), .acc_y(acc_y), .acc_z(acc_z), .tap_prefilt(tap_prefilt),
        .ud_change(ud_change), .orient_value(orient_value), .flat_now(flat_now),
        .tap_quiet_ms(tap_quiet_ms), .tap_shock_ms(tap_shock_ms),
        .tap_window_ms(tap_window_ms), .tap_threshold_half(tap_threshold_half),
        .lowpower_allow(lowpower_allow), .orient_hyst(orient_hyst), .orient_mode(orient_mode),
        .orient_block_theta(orient_block_theta), .orient_block_big(orient_block_big),
        .orient_slope_dg(orient_slope_dg), .orient_block_unstable(orient_block_unstable),
        .orient_theta(orient_theta), .orient_x(orient_x), .orient_y(orient_y),
        .orient_z(orient_z), .orient_ud_irq(orient_ud_irq), .flat_theta(flat_theta),
        .flat_hysteresis(flat_hysteresis), .flat_hold_ms(flat_hold_ms),
        .flat_settled(flat_settled), .foc_gyr_en(foc_gyr_en), .foc_x(foc_x),
        .foc_y(foc_y), .foc_z(foc_z)
    );

    initial begin
        forever #20 hclk = ~hclk;
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // One single word transfer; entered just after a rising edge.
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask

    task automatic wreg(input int i, input logic [31:0] wd);
        xfer(1'b1, 12'((8'h63 + i) * 4), wd & {24'h0, MSKV[i]});
        mr[i] = wd[7:0] & MSKV[i];
    endtask

    task automatic rreg(input int i);
        xfer(1'b0, 12'((8'h63 + i) * 4), 32'h0);
        chk("rdata", {24'h0, mr[i]}, q);
        chk("hresp", 32'h0, hresp);
    endtask

    task automatic check_outs;
        logic [4:0] th;
        logic [1:0] bk;
        th = mr[1][4:0];
        bk = mr[2][3:2];
        chk("quiet", mr[0][7] ? 20 : 30, tap_quiet_ms);
        chk("shock", mr[0][6] ? 75 : 50, tap_shock_ms);
        chk("window", DTAP[mr[0][2:0]], tap_window_ms);
        chk("thr", 32'((th == 0 ? 1 : 2 * th) << acc_range), tap_threshold_half);
        chk("ohyst", mr[2][7:4], orient_hyst);
        chk("blk", {bk != 0, bk != 0}, {orient_block_theta, orient_block_big});
        chk("slope", bk == 2 ? 2 : (bk == 3 ? 4 : 0), orient_slope_dg);
        chk("omode", mr[2][1:0], orient_mode);
        chk("otheta", mr[3][5:0], orient_theta);
        chk("ftheta", mr[4][5:0], flat_theta);
        chk("fhold", HOLD[mr[5][5:4]], flat_hold_ms);
        chk("fhyst", mr[5][2:0], flat_hysteresis);
        chk("fgyr", mr[6][6], foc_gyr_en);
        chk("facc", mr[6][5:0], {foc_x, foc_y, foc_z});
    endtask

    task automatic settle;
        repeat (2) @(posedge hclk);
        #1;
        check_outs();
        @(posedge hclk);
    endtask

    task automatic do_reset;
        hresetn <= 1'b0;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        for (int i = 0; i < 7; i++) mr[i] = RSTV[i];
        @(posedge hclk);
        for (int i = 0; i < 7; i++) rreg(i);
        settle();
    endtask

    initial begin
        repeat (20000) @(posedge hclk);
        err_count++;
        stop_test();
    end

    initial begin
        do_reset();
        $display("test reset done");
        for (int c = 0; c < 8; c++) begin
            acc_range <= c[1:0];
            wreg(0, {c[0], c[1], 3'h0, c[2:0]});
            wreg(1, c * 3);
            wreg(2, {c[3:0], c[1:0], c[2:1]});
            wreg(5, {2'h0, c[1:0], 1'h0, c[2:0]});
            wreg(6, {1'h0, c[2], c[1:0], c[2:1], c[1:0]});
            settle();
        end
        $display("test codes done");
        for (int k = 0; k < 28; k++) begin
            d = $random(seed);
            acc_range <= 2'($random(seed));
            wreg(k % 7, d);
            rreg(k % 7);
            settle();
        end
        $display("test random done");
        xfer(1'b1, 12'h188, 32'hff);
        xfer(1'b1, 12'h1a8, 32'hff);
        xfer(1'b1, 12'h58c, 32'hff);
        foreach (HOLD[j]) begin
            xfer(1'b0, j == 0 ? 12'h188 : (j == 1 ? 12'h1a8 : 12'h58c), 32'h0);
            chk("unmapped", 32'h0, q);
        end
        for (int i = 0; i < 7; i++) rreg(i);
        $display("test unmapped done");
        for (int r = 0; r < 2; r++) begin
            tap_prefilt <= r[0];
            wreg(3, {r[0], r[0], 6'h08});
            acc_x <= 16'($random(seed));
            acc_y <= 16'($random(seed));
            acc_z <= 16'($random(seed));
            repeat (3) @(posedge hclk);
            #1;
            chk("lowpwr", !r[0], lowpower_allow);
            chk("orient_x", r ? acc_y : acc_x, orient_x);
            chk("orient_y", r ? acc_z : acc_y, orient_y);
            chk("orient_z", r ? acc_x : acc_z, orient_z);
            @(posedge hclk);
            ud_change <= 1'b1;
            @(posedge hclk);
            ud_change <= 1'b0;
            #1;
            chk("udirq", r[0], orient_ud_irq);
            @(posedge hclk);
            #1;
            chk("udirq_end", 1'b0, orient_ud_irq);
            @(posedge hclk);
        end
        $display("test orient done");
        wreg(2, 8'h1c);
        orient_value <= 3'h5;
        repeat (50) @(posedge hclk);
        #1;
        chk("unstable", 1'b1, orient_block_unstable);
        repeat (400) @(posedge hclk);
        #1;
        chk("stable", 1'b0, orient_block_unstable);
        @(posedge hclk);
        wreg(5, 8'h11);
        flat_now <= 1'b1;
        repeat (2400) @(posedge hclk);
        #1;
        chk("flat_early", 1'b0, flat_settled);
        repeat (300) @(posedge hclk);
        #1;
        chk("flat_held", 1'b1, flat_settled);
        @(posedge hclk);
        wreg(5, 8'h01);
        flat_now <= 1'b0;
        settle();
        #1;
        chk("flat_zero", 1'b1, flat_settled);
        $display("test timers done");
        ce <= 1'b0;
        @(posedge hclk);
        #1;
        chk("stall", 1'b0, hreadyout);
        @(posedge hclk);
        fork
            wreg(6, 8'hd5);
            begin
                repeat (5) @(posedge hclk);
                ce <= 1'b1;
            end
        join
        settle();
        do_reset();
        $display("test stall and reset done");
        stop_test();
    end
endmodule
`default_nettype wire

// ### verilog/mgc_config_regs.sv
// Gesture and offset configuration registers on an AHB-Lite slave.
// Assumes one clock, word-only single transfers; answers have no wait states while ce is high.
//
// Decided for this implementation: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "mgc_map.svh"
module mgc_config_regs #(
    parameter int ADDR_W    = 12,
    parameter int MS_CYCLES = `MGC_CLK_HZ / `MGC_HZ_PER_KHZ
) (
    // Clock, reset and enable.
    input  wire logic                      hclk,
    input  wire logic                      hresetn,
    input  wire logic                      ce,
    // AHB-Lite slave.
    input  wire logic                      hsel,
    input  wire logic [ADDR_W-1:0]         haddr,
    input  wire logic [1:0]                htrans,
    input  wire logic                      hwrite,
    input  wire logic [2:0]                hsize,
    input  wire logic [31:0]               hwdata,
    input  wire logic                      hready,
    output logic                           hreadyout,
    output logic                           hresp,
    output logic [31:0]                    hrdata,
    // Sensor side inputs.
    input  wire logic [1:0]                acc_range,
    input  wire logic [15:0]               acc_x,
    input  wire logic [15:0]               acc_y,
    input  wire logic [15:0]               acc_z,
    input  wire logic                      tap_prefilt,
    input  wire logic                      ud_change,
    input  wire logic [2:0]                orient_value,
    input  wire logic                      flat_now,
    // Tap settings.
    output mgc_pkg::mgc_ms_t               tap_quiet_ms,
    output mgc_pkg::mgc_ms_t               tap_shock_ms,
    output mgc_pkg::mgc_ms_t               tap_window_ms,
    output logic [8:0]                     tap_threshold_half,
    output logic                           lowpower_allow,
    // Orientation settings.
    output logic [3:0]                     orient_hyst,
    output mgc_pkg::mgc_orient_mode_t      orient_mode,
    output logic                           orient_block_theta,
    output logic                           orient_block_big,
    output logic [2:0]                     orient_slope_dg,
    output logic                           orient_block_unstable,
    output logic [5:0]                     orient_theta,
    output logic [15:0]                    orient_x,
    output logic [15:0]                    orient_y,
    output logic [15:0]                    orient_z,
    output logic                           orient_ud_irq,
    // Flat settings.
    output logic [5:0]                     flat_theta,
    output logic [2:0]                     flat_hysteresis,
    output mgc_pkg::mgc_ms_t               flat_hold_ms,
    output logic                           flat_settled,
    // Offset compensation.
    output logic                           foc_gyr_en,
    output mgc_pkg::mgc_foc_target_t       foc_x,
    output mgc_pkg::mgc_foc_target_t       foc_y,
    output mgc_pkg::mgc_foc_target_t       foc_z
);
    localparam mgc_pkg::mgc_byte_t RST [0:`MGC_NREG-1] = '{
        `MGC_RST_TAP_TIM, `MGC_RST_TAP_THR, `MGC_RST_ORI_A,
        `MGC_RST_ORI_B, `MGC_RST_FLAT_ANG, `MGC_RST_FLAT_HLD,
        `MGC_RST_FOC};
    localparam mgc_pkg::mgc_byte_t MSK [0:`MGC_NREG-1] = '{
        `MGC_MSK_TAP_TIM, `MGC_MSK_TAP_THR, `MGC_MSK_ORI_A,
        `MGC_MSK_ORI_B, `MGC_MSK_FLAT_ANG, `MGC_MSK_FLAT_HLD,
        `MGC_MSK_FOC};

    generate
        if (ADDR_W < 10 || ADDR_W > 32 || MS_CYCLES < 1 || MS_CYCLES > 65536) begin : g_bad_par
            $error("mgc_config_regs: unsupported parameter value");
        end
    endgenerate

    // Word index to register slot, with a hit flag on top.
    function automatic logic [3:0] reg_slot(input logic [7:0] idx);
        logic [7:0] off;
        off = idx - `MGC_IDX_TAP_TIM;
        if (idx >= `MGC_IDX_TAP_TIM && idx <= `MGC_IDX_FOC) begin
            reg_slot = {1'b1, off[2:0]};
        end else begin
            reg_slot = 4'h0;
        end
    endfunction

    mgc_pkg::mgc_byte_t regs [0:`MGC_NREG-1];
    logic               wr_pend;
    logic               wr_hit;
    logic [2:0]         wr_slot;
    logic [15:0]        ms_cnt;
    logic               ms_tick;
    mgc_pkg::mgc_ms_t   stable_ms;
    mgc_pkg::mgc_ms_t   flat_ms;
    logic [2:0]         orient_last;
    logic               flat_last;

    // Address phase decode.
    wire        take      = ce && hsel && hready && htrans[1];
    wire        hi_zero   = (ADDR_W == 10) || (haddr[ADDR_W-1:2] >> 8) == '0;
    wire [3:0]  a_dec     = reg_slot(haddr[9:2]);
    wire        a_hit     = a_dec[3] && hi_zero;
    wire [2:0]  a_slot    = a_dec[2:0];
    wire        fwd       = wr_pend && wr_hit && wr_slot == a_slot;
    wire [7:0]  wr_byte   = hwdata[7:0] & MSK[wr_slot];
    wire [7:0]  rd_byte   = fwd ? wr_byte : regs[a_slot];
    wire [31:0] next_rdata = (take && !hwrite && a_hit) ? {24'h0, rd_byte} : 32'h0;

    assign hreadyout = ce;
    assign hresp     = 1'b0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_hit  <= 1'b0;
            wr_slot <= 3'h0;
            hrdata  <= 32'h0;
        end else if (ce) begin
            wr_pend <= take && hwrite;
            wr_hit  <= a_hit;
            wr_slot <= a_slot;
            hrdata  <= next_rdata;
        end
    end

    // Register storage; reserved bits are dropped on write.
    genvar g;
    generate
        for (g = 0; g < `MGC_NREG; g++) begin : g_reg
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    regs[g] <= RST[g];
                end else if (ce && wr_pend && wr_hit && wr_slot == 3'(g)) begin
                    regs[g] <= wr_byte;
                end
            end
        end
    endgenerate

    // Field views.
    wire [7:0] r_tap  = regs[0];
    wire [7:0] r_thr  = regs[1];
    wire [7:0] r_ora  = regs[2];
    wire [7:0] r_orb  = regs[3];
    wire [7:0] r_fla  = regs[4];
    wire [7:0] r_flh  = regs[5];
    wire [7:0] r_foc  = regs[6];
    wire [4:0] tap_threshold_code      = r_thr[4:0];
    wire       axis_rotate_sel         = r_orb[7];
    wire       updown_change_int_allow = r_orb[6];
    wire [1:0] blk_code                = r_ora[3:2];

    wire [11:0] dtap_ms =
        (r_tap[2:0] == 3'h0) ? `MGC_DTAP0_MS :
        (r_tap[2:0] == 3'h1) ? `MGC_DTAP1_MS :
        (r_tap[2:0] == 3'h2) ? `MGC_DTAP2_MS :
        (r_tap[2:0] == 3'h3) ? `MGC_DTAP3_MS :
        (r_tap[2:0] == 3'h4) ? `MGC_DTAP4_MS :
        (r_tap[2:0] == 3'h5) ? `MGC_DTAP5_MS :
        (r_tap[2:0] == 3'h6) ? `MGC_DTAP6_MS : `MGC_DTAP7_MS;
    wire [5:0]  thr_half2g = (tap_threshold_code == 5'h00) ? 6'h01
                                                          : {tap_threshold_code, 1'b0};
    wire [8:0]  next_thr   = 9'(thr_half2g) << acc_range;
    wire [11:0] hold_ms =
        (r_flh[5:4] == 2'h0) ? `MGC_FLAT0_MS :
        (r_flh[5:4] == 2'h1) ? `MGC_FLAT1_MS :
        (r_flh[5:4] == 2'h2) ? `MGC_FLAT2_MS : `MGC_FLAT3_MS;
    wire [2:0]  slope_dg =
        (blk_code == mgc_pkg::MGC_BLK_SLOPE) ? `MGC_SLOPE_LO_DG :
        (blk_code == mgc_pkg::MGC_BLK_FULL)  ? `MGC_SLOPE_HI_DG : 3'h0;
    wire        stable_ok = stable_ms >= `MGC_STABLE_MS;
    wire        orient_chg = orient_value != orient_last;
    wire        flat_chg   = flat_now != flat_last;

    // Tap, orientation, flat and offset outputs.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tap_quiet_ms          <= `MGC_QUIET0_MS;
            tap_shock_ms          <= `MGC_SHOCK0_MS;
            tap_window_ms         <= `MGC_DTAP0_MS;
            tap_threshold_half    <= 9'h000;
            lowpower_allow        <= 1'b1;
            orient_hyst           <= 4'h0;
            orient_mode           <= mgc_pkg::MGC_OM_SYM;
            orient_block_theta    <= 1'b0;
            orient_block_big      <= 1'b0;
            orient_slope_dg       <= 3'h0;
            orient_block_unstable <= 1'b0;
            orient_theta          <= 6'h00;
            flat_theta            <= 6'h00;
            flat_hysteresis       <= 3'h0;
            flat_hold_ms          <= `MGC_FLAT0_MS;
            foc_gyr_en            <= 1'b0;
            foc_x                 <= mgc_pkg::MGC_FOC_OFF;
            foc_y                 <= mgc_pkg::MGC_FOC_OFF;
            foc_z                 <= mgc_pkg::MGC_FOC_OFF;
        end else if (ce) begin
            tap_quiet_ms          <= r_tap[7] ? `MGC_QUIET1_MS : `MGC_QUIET0_MS;
            tap_shock_ms          <= r_tap[6] ? `MGC_SHOCK1_MS : `MGC_SHOCK0_MS;
            tap_window_ms         <= dtap_ms;
            tap_threshold_half    <= next_thr;
            lowpower_allow        <= !tap_prefilt;
            orient_hyst           <= r_ora[7:4];
            orient_mode           <= mgc_pkg::mgc_orient_mode_t'(r_ora[1:0]);
            orient_block_theta    <= blk_code != mgc_pkg::MGC_BLK_NONE;
            orient_block_big      <= blk_code != mgc_pkg::MGC_BLK_NONE;
            orient_slope_dg       <= slope_dg;
            orient_block_unstable <= blk_code == mgc_pkg::MGC_BLK_FULL && !stable_ok;
            orient_theta          <= r_orb[5:0];
            flat_theta            <= r_fla[5:0];
            flat_hysteresis       <= r_flh[2:0];
            flat_hold_ms          <= hold_ms;
            foc_gyr_en            <= r_foc[6];
            foc_x                 <= mgc_pkg::mgc_foc_target_t'(r_foc[5:4]);
            foc_y                 <= mgc_pkg::mgc_foc_target_t'(r_foc[3:2]);
            foc_z                 <= mgc_pkg::mgc_foc_target_t'(r_foc[1:0]);
        end
    end

    // Axis remap and up/down event gate.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            orient_x      <= 16'h0000;
            orient_y      <= 16'h0000;
            orient_z      <= 16'h0000;
            orient_ud_irq <= 1'b0;
        end else if (ce) begin
            orient_x      <= axis_rotate_sel ? acc_y : acc_x;
            orient_y      <= axis_rotate_sel ? acc_z : acc_y;
            orient_z      <= axis_rotate_sel ? acc_x : acc_z;
            orient_ud_irq <= ud_change && updown_change_int_allow;
        end
    end

    // Millisecond tick.
    assign ms_tick = ms_cnt == 16'(MS_CYCLES - 1);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ms_cnt <= 16'h0000;
        end else if (ce) begin
            ms_cnt <= ms_tick ? 16'h0000 : ms_cnt + 16'h0001;
        end
    end

    // Stability timers, restarted on every change of their input.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            orient_last <= 3'h0;
            flat_last   <= 1'b0;
            stable_ms   <= 12'h000;
            flat_ms     <= 12'h000;
        end else if (ce) begin
            orient_last <= orient_value;
            flat_last   <= flat_now;
            if (orient_chg) begin
                stable_ms <= 12'h000;
            end else if (ms_tick && stable_ms != `MGC_MS_MAX) begin
                stable_ms <= stable_ms + 12'h001;
            end
            if (flat_chg) begin
                flat_ms <= 12'h000;
            end else if (ms_tick && flat_ms != `MGC_MS_MAX) begin
                flat_ms <= flat_ms + 12'h001;
            end
        end
    end

    assign flat_settled = !flat_chg && flat_ms >= flat_hold_ms;

    // Checks.
    sequence s_wr_then_rd;
        take && hwrite && a_hit ##1 ce && take && !hwrite && fwd;
    endsequence

    property p_quiet;
        @(posedge hclk) disable iff (!hresetn)
        ce && !r_tap[7] |=> tap_quiet_ms == `MGC_QUIET0_MS;
    endproperty
    a_quiet: assert property (p_quiet) else $error("quiet time wrong");

    property p_shock;
        @(posedge hclk) disable iff (!hresetn)
        ce && r_tap[6] |=> tap_shock_ms == `MGC_SHOCK1_MS;
    endproperty
    a_shock: assert property (p_shock) else $error("shock time wrong");

    property p_window;
        @(posedge hclk) disable iff (!hresetn)
        ce && r_tap[2:0] == 3'h7 |=> tap_window_ms == `MGC_DTAP7_MS;
    endproperty
    a_window: assert property (p_window) else $error("window wrong");

    property p_lowpower;
        @(posedge hclk) disable iff (!hresetn)
        ce && tap_prefilt |=> !lowpower_allow;
    endproperty
    a_lowpower: assert property (p_lowpower) else $error("low power allowed");

    property p_thr;
        @(posedge hclk) disable iff (!hresetn)
        ce && tap_threshold_code == 5'h00 && acc_range == 2'h0 |=> tap_threshold_half == 9'h001;
    endproperty
    a_thr: assert property (p_thr) else $error("zero threshold wrong");

    property p_rotate;
        @(posedge hclk) disable iff (!hresetn)
        ce && axis_rotate_sel |=> orient_x == $past(acc_y) && orient_z == $past(acc_x);
    endproperty
    a_rotate: assert property (p_rotate) else $error("axis remap wrong");

    property p_ud;
        @(posedge hclk) disable iff (!hresetn)
        ce && ud_change && !updown_change_int_allow |=> !orient_ud_irq;
    endproperty
    a_ud: assert property (p_ud) else $error("masked up/down event raised");

    property p_unstable;
        @(posedge hclk) disable iff (!hresetn)
        ce && orient_chg && blk_code == 2'h3 ##1 ce |=> orient_block_unstable;
    endproperty
    a_unstable: assert property (p_unstable) else $error("no stability block");

    property p_flat;
        @(posedge hclk) disable iff (!hresetn)
        ce && flat_chg |-> !flat_settled ##1 (flat_hold_ms == 12'h000 || !flat_settled);
    endproperty
    a_flat: assert property (p_flat) else $error("flat settled on change");

    property p_fwd;
        @(posedge hclk) disable iff (!hresetn)
        s_wr_then_rd |=> hrdata[7:0] == $past(wr_byte);
    endproperty
    a_fwd: assert property (p_fwd) else $error("read after write stale");
endmodule
`default_nettype wire

// ### verilog/mgc_map.svh
// Register indices, reset values, write masks, clock rate, times and slope values.
// Assumes inclusion by the register block only.
`ifndef MGC_MAP_SVH
`define MGC_MAP_SVH
`define MGC_NREG         7
`define MGC_IDX_TAP_TIM  8'h63
`define MGC_IDX_TAP_THR  8'h64
`define MGC_IDX_ORI_A    8'h65
`define MGC_IDX_ORI_B    8'h66
`define MGC_IDX_FLAT_ANG 8'h67
`define MGC_IDX_FLAT_HLD 8'h68
`define MGC_IDX_FOC      8'h69
`define MGC_RST_TAP_TIM  8'h04
`define MGC_RST_TAP_THR  8'h0a
`define MGC_RST_ORI_A    8'h18
`define MGC_RST_ORI_B    8'h48
`define MGC_RST_FLAT_ANG 8'h08
`define MGC_RST_FLAT_HLD 8'h11
`define MGC_RST_FOC      8'h00
`define MGC_MSK_TAP_TIM  8'hc7
`define MGC_MSK_TAP_THR  8'h1f
`define MGC_MSK_ORI_A    8'hff
`define MGC_MSK_ORI_B    8'hff
`define MGC_MSK_FLAT_ANG 8'h3f
`define MGC_MSK_FLAT_HLD 8'h37
`define MGC_MSK_FOC      8'h7f
`define MGC_CLK_HZ       25000000
`define MGC_HZ_PER_KHZ   1000
`define MGC_QUIET0_MS    12'h01e
`define MGC_QUIET1_MS    12'h014
`define MGC_SHOCK0_MS    12'h032
`define MGC_SHOCK1_MS    12'h04b
`define MGC_DTAP0_MS     12'h032
`define MGC_DTAP1_MS     12'h064
`define MGC_DTAP2_MS     12'h096
`define MGC_DTAP3_MS     12'h0c8
`define MGC_DTAP4_MS     12'h0fa
`define MGC_DTAP5_MS     12'h177
`define MGC_DTAP6_MS     12'h1f4
`define MGC_DTAP7_MS     12'h2bc
`define MGC_STABLE_MS    12'h064
`define MGC_FLAT0_MS     12'h000
`define MGC_FLAT1_MS     12'h280
`define MGC_FLAT2_MS     12'h500
`define MGC_FLAT3_MS     12'ha00
`define MGC_MS_MAX       12'hfff
`define MGC_SLOPE_LO_DG  3'h2
`define MGC_SLOPE_HI_DG  3'h4
`endif

// ### verilog/mgc_pkg.sv
// Types shared by the configuration register block.
// Assumes the map header holds every number.
`default_nettype none
package mgc_pkg;
    typedef logic [7:0]  mgc_byte_t;
    typedef logic [11:0] mgc_ms_t;
    typedef enum logic [1:0] {
        MGC_OM_SYM  = 2'h0,
        MGC_OM_HIGH = 2'h1,
        MGC_OM_LOW  = 2'h2,
        MGC_OM_SYM2 = 2'h3
    } mgc_orient_mode_t;
    typedef enum logic [1:0] {
        MGC_BLK_NONE  = 2'h0,
        MGC_BLK_THETA = 2'h1,
        MGC_BLK_SLOPE = 2'h2,
        MGC_BLK_FULL  = 2'h3
    } mgc_block_t;
    typedef enum logic [1:0] {
        MGC_FOC_OFF  = 2'h0,
        MGC_FOC_POS  = 2'h1,
        MGC_FOC_NEG  = 2'h2,
        MGC_FOC_ZERO = 2'h3
    } mgc_foc_target_t;
endpackage
`default_nettype wire
